// ===== src/ovl_nodata_proto.sv
// Purpose: device-side overlap idle and non-data command state machine
// Assumes: event inputs are one-cycle pulses from decode logic on core_clk_i
// Notes: INTRQ is driven in every state but deselected overlap idle; there it is released
`timescale 1ns/10ps
`default_nettype none
module ovl_nodata_proto (
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic dev_wr_i,
	input wire logic dev_sel_this_i,
	input wire logic cmd_wr_i,
	input wire ovl_proto_pkg::cmd_kind_t cmd_kind_i,
	input wire logic status_rd_i,
	input wire logic nien_i,
	input wire logic exec_done_i,
	input wire logic exec_error_i,
	input wire logic release_i,
	input wire logic release_pend_i,
	input wire logic release_serv_i,
	input wire logic [ovl_proto_pkg::TAG_W-1:0] svc_tag_i,
	output logic bsy_o,
	output logic drq_o,
	output logic err_o,
	output logic intrq_o,
	output logic intrq_oe_o,
	output logic service_go_o,
	output logic new_cmd_go_o,
	output logic [ovl_proto_pkg::TAG_W-1:0] service_tag_o,
	output ovl_proto_pkg::proto_state_t state_o
);
	import ovl_proto_pkg::*;

	block_state_t cur;
	block_state_t next_cur;
	logic intr_ok;
	logic wr_other;
	logic wr_this;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	assign intr_ok = cur.pending && !nien_i;
	assign wr_other = dev_wr_i && !dev_sel_this_i;
	assign wr_this = dev_wr_i && dev_sel_this_i;

	always_comb begin
		next_cur = cur;
		next_cur.svc_go = 1'b0;
		next_cur.cmd_go = 1'b0;
		unique case (cur.fsm)
			sel_nointr_plain_idle: begin
				next_cur.intrq = 1'b0;
				if (cmd_wr_i && cmd_kind_i == CMD_NODATA) begin
					next_cur.fsm = nodata_execute_state;
					next_cur.bsy = 1'b1;
					next_cur.pending = 1'b1;
					next_cur.err = 1'b0;
				end
			end
			nodata_execute_state: begin
				if (exec_done_i) begin
					next_cur.bsy = 1'b0;
					next_cur.err = exec_error_i;
					next_cur.intrq = !nien_i;
					next_cur.fsm = nien_i ? sel_nointr_plain_idle : sel_intr_plain_idle;
				end
			end
			sel_intr_plain_idle: begin
				if (status_rd_i || nien_i) begin
					// Read clears pending; nIEN only masks it
					next_cur.pending = cur.pending && !status_rd_i;
					next_cur.intrq = 1'b0;
					next_cur.fsm = sel_nointr_plain_idle;
				end
			end
			sel_intr_released_idle: begin
				if (status_rd_i) begin
					next_cur.pending = 1'b0;
					next_cur.intrq = 1'b0;
					next_cur.fsm = sel_nointr_released_idle;
				end else if (wr_other) begin
					next_cur.intrq = 1'b0;
					next_cur.fsm = deselected_overlap_idle;
				end
			end
			sel_nointr_released_idle: begin
				if (wr_other) begin
					next_cur.fsm = deselected_overlap_idle;
				end
			end
			sel_intr_service_idle: begin
				if (wr_other) begin
					next_cur.intrq = 1'b0;
					next_cur.fsm = deselected_overlap_idle;
				end else if (cmd_wr_i && cmd_kind_i == CMD_SERVICE) begin
					next_cur.tag = svc_tag_i;
					next_cur.intrq = 1'b0;
					next_cur.pending = 1'b0;
					next_cur.svc_go = 1'b1;
					next_cur.fsm = sel_nointr_plain_idle;
				end else if (cmd_wr_i && cmd_kind_i == CMD_OVERLAP) begin
					next_cur.intrq = 1'b0;
					next_cur.pending = 1'b0;
					next_cur.cmd_go = 1'b1;
					next_cur.fsm = sel_nointr_plain_idle;
				end else if (status_rd_i) begin
					next_cur.pending = 1'b0;
					next_cur.intrq = 1'b0;
					next_cur.fsm = sel_nointr_service_idle;
				end
			end
			sel_nointr_service_idle: begin
				next_cur.intrq = 1'b0;
				if (wr_other) begin
					next_cur.fsm = deselected_overlap_idle;
				end else if (cmd_wr_i && cmd_kind_i == CMD_SERVICE) begin
					next_cur.tag = svc_tag_i;
					next_cur.svc_go = 1'b1;
					next_cur.fsm = sel_nointr_plain_idle;
				end else if (cmd_wr_i && cmd_kind_i == CMD_OVERLAP) begin
					next_cur.cmd_go = 1'b1;
					next_cur.fsm = sel_nointr_plain_idle;
				end
			end
			deselected_overlap_idle: begin
				next_cur.bsy = 1'b0;
				next_cur.intrq = 1'b0;
				if (wr_this && (cur.rel || cur.serv)) begin
					next_cur.intrq = intr_ok;
					if (cur.serv) begin
						next_cur.fsm = intr_ok ? sel_intr_service_idle : sel_nointr_service_idle;
					end else begin
						next_cur.fsm = intr_ok ? sel_intr_released_idle : sel_nointr_released_idle;
					end
				end else if (wr_this) begin
					next_cur.fsm = sel_nointr_plain_idle;
				end
			end
		endcase
		// A command released from the overlap engine; REL and SERV kept for reselection
		if (release_i && cur.fsm != nodata_execute_state && cur.fsm != deselected_overlap_idle) begin
			next_cur.rel = 1'b1;
			next_cur.serv = release_serv_i;
			next_cur.pending = release_pend_i;
			next_cur.bsy = 1'b0;
			next_cur.intrq = release_pend_i && !nien_i;
			if (release_serv_i) begin
				next_cur.fsm = (release_pend_i && !nien_i) ? sel_intr_service_idle : sel_nointr_service_idle;
			end else begin
				next_cur.fsm = (release_pend_i && !nien_i) ? sel_intr_released_idle : sel_nointr_released_idle;
			end
		end
		// Serviced or superseded commands leave the overlap bookkeeping
		if (next_cur.svc_go || next_cur.cmd_go) begin
			next_cur.rel = 1'b0;
			next_cur.serv = 1'b0;
		end
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cur <= STATE_RESET;
		end else begin
			cur <= next_cur;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Drive the line, low when negated, in all but deselected overlap idle; release it there
	assign intrq_oe_o = (cur.fsm != deselected_overlap_idle);
	assign intrq_o = cur.intrq;
	assign bsy_o = cur.bsy;
	assign drq_o = 1'b0;
	assign err_o = cur.err;
	assign service_go_o = cur.svc_go;
	assign new_cmd_go_o = cur.cmd_go;
	assign service_tag_o = cur.tag;
	assign state_o = cur.fsm;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!reset_n_i);

	sequence s_svc_intr_other;
		cur.fsm == sel_intr_service_idle && wr_other && !release_i;
	endsequence
	sequence s_desel_quiet;
		cur.fsm == deselected_overlap_idle && !intrq_oe_o && !bsy_o;
	endsequence

	a_desel_release: assert property (s_svc_intr_other |=> s_desel_quiet)
		else $error("intr service idle did not release on other select");
	a_service_tag: assert property (cur.fsm == sel_intr_service_idle && cmd_wr_i && cmd_kind_i == CMD_SERVICE
		&& !wr_other && !release_i |=> service_go_o && !intrq_o && service_tag_o == $past(svc_tag_i))
		else $error("service write did not load tag and drop interrupt");
	a_new_cmd_start: assert property (cur.fsm == sel_nointr_service_idle && cmd_wr_i && cmd_kind_i == CMD_OVERLAP
		&& !wr_other && !release_i |=> new_cmd_go_o ##1 !new_cmd_go_o)
		else $error("new command start pulse wrong");
	a_reselect_intr: assert property (cur.fsm == deselected_overlap_idle && wr_this && cur.rel && !cur.serv
		&& cur.pending && !nien_i |=> intrq_o && intrq_oe_o && cur.fsm == sel_intr_released_idle)
		else $error("reselect with pending interrupt did not assert INTRQ");
	a_reselect_quiet: assert property (cur.fsm == deselected_overlap_idle && wr_this && cur.serv
		&& nien_i |=> !intrq_o && cur.fsm == sel_nointr_service_idle)
		else $error("reselect with nIEN set asserted INTRQ");
	a_busy_raise: assert property (cur.fsm == sel_nointr_plain_idle && cmd_wr_i && cmd_kind_i == CMD_NODATA
		&& !release_i |=> bsy_o && cur.pending)
		else $error("non-data write did not raise BSY");
	a_done_intr: assert property (cur.fsm == nodata_execute_state && exec_done_i && !nien_i
		|=> !bsy_o && intrq_o && err_o == $past(exec_error_i))
		else $error("completion with nIEN clear did not assert INTRQ");
	a_status_clear: assert property (cur.fsm == sel_intr_plain_idle && status_rd_i && !release_i
		|=> !intrq_o && !cur.pending ##1 (!intrq_o || $past(release_i)))
		else $error("status read did not clear interrupt");
	a_nien_mask: assert property (cur.fsm == sel_intr_plain_idle && nien_i && !release_i
		|=> !intrq_o && cur.fsm == sel_nointr_plain_idle)
		else $error("nIEN set did not negate INTRQ");
	a_plain_quiet: assert property (cur.fsm == sel_nointr_plain_idle |-> !bsy_o && !drq_o && !intrq_o)
		else $error("no-intr plain idle not quiet");
endmodule
`default_nettype wire

// ===== src/ovl_proto_pkg.sv
// Purpose: shared constants and types for the overlap idle and non-data protocol block
// Assumes: 100 MHz core clock, register decode logic delivers one-cycle event pulses
// Notes: all response times are met in one clock after the strobe event
//
// Function
// - Service-intr state, other-device select: release INTRQ, go deselected overlap idle.
// - Service-intr state, SERVICE write: load tag, drop INTRQ, go to service return.
// - Service-intr state, other overlapped command: drop INTRQ, start new command protocol.
// - Hold no-intr service idle with REL and SERV set and INTRQ negated.
// - No-intr service state, other-device select: go deselected overlap idle.
// - No-intr service state, SERVICE write: load tag, go to service return.
// - No-intr service state, other overlapped command: start new command protocol.
// - Deselected with REL or SERV: BSY, DRQ zero, INTRQ released.
// - Reselect, pending, nIEN zero, REL only: assert INTRQ, enter intr released idle.
// - Reselect, no pending or nIEN one, REL only: enter no-intr released idle.
// - Reselect, pending, nIEN zero, SERV set: assert INTRQ, enter intr service idle.
// - Reselect, no pending or nIEN one, SERV set: enter no-intr service idle.
// - Non-data command write: raise BSY within 400 ns, execute, set pending.
// - Execution done, nIEN zero: set errors, clear BSY, assert INTRQ, intr plain idle.
// - Execution done, nIEN one: set errors, clear BSY, no-intr plain idle.
// - Intr plain idle, status read: clear pending, drop INTRQ within 400 ns.
// - nIEN set while INTRQ asserted in plain idle: negate INTRQ, no-intr idle.
// - No-intr plain idle keeps BSY, DRQ zero and INTRQ negated.
package ovl_proto_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int RESP_MAX_NS = 400;
	// Longest response rounds down to whole cycles
	localparam int RESP_MAX_CYC = RESP_MAX_NS / CLK_PERIOD_NS;
	localparam int TAG_W = 5;
	localparam logic [TAG_W-1:0] TAG_RESET = 5'h00;

	typedef enum logic [1:0] {
		CMD_NODATA = 2'h0,
		CMD_SERVICE = 2'h1,
		CMD_OVERLAP = 2'h2
	} cmd_kind_t;

	// Gray codes along the usual path
	typedef enum logic [2:0] {
		sel_nointr_plain_idle = 3'h0,
		nodata_execute_state = 3'h1,
		sel_intr_plain_idle = 3'h3,
		sel_intr_released_idle = 3'h2,
		sel_nointr_released_idle = 3'h6,
		sel_intr_service_idle = 3'h7,
		sel_nointr_service_idle = 3'h5,
		deselected_overlap_idle = 3'h4
	} proto_state_t;

	typedef struct packed {
		proto_state_t fsm;
		logic pending;
		logic rel;
		logic serv;
		logic intrq;
		logic bsy;
		logic err;
		logic svc_go;
		logic cmd_go;
		logic [TAG_W-1:0] tag;
	} block_state_t;

	localparam block_state_t STATE_RESET = '{
		fsm: sel_nointr_plain_idle, pending: 1'b0, rel: 1'b0, serv: 1'b0, intrq: 1'b0,
		bsy: 1'b0, err: 1'b0, svc_go: 1'b0, cmd_go: 1'b0, tag: TAG_RESET};
endpackage

// ===== test/host_nodata_model.sv
// Purpose: host model that issues one non-data command and polls status
// Assumes: strobes are one-cycle pulses driven 1 ns after the rising edge
// Notes: status data is the bsy and err levels sampled at the read edge
`timescale 1ns/10ps
`default_nettype none
module host_nodata_model (
	input wire logic core_clk_i,
	input wire logic start_i,
	input wire logic nien_i,
	input wire logic intrq_i,
	input wire logic bsy_i,
	input wire logic err_i,
	output logic cmd_wr_o,
	output logic status_rd_o,
	output logic done_o,
	output logic err_seen_o
);
	logic busy;
	initial begin
		cmd_wr_o = 1'b0;
		status_rd_o = 1'b0;
		done_o = 1'b0;
		err_seen_o = 1'b0;
		forever begin
			@(posedge core_clk_i iff start_i);
			#1 done_o = 1'b0;
			cmd_wr_o = 1'b1;
			@(posedge core_clk_i);
			#1 cmd_wr_o = 1'b0;
			if (!nien_i) begin
				@(posedge core_clk_i iff intrq_i === 1'b1);
			end else begin
				// No interrupt to wait for, so settle time comes first
				repeat (ovl_proto_pkg::RESP_MAX_CYC) @(posedge core_clk_i);
			end
			#1 busy = 1'b1;
			while (busy) begin
				status_rd_o = 1'b1;
				@(posedge core_clk_i);
				busy = bsy_i;
				err_seen_o = err_i;
				#1 status_rd_o = 1'b0;
				@(posedge core_clk_i);
				#1;
			end
			done_o = 1'b1;
		end
	end
endmodule
`default_nettype wire

// ===== test/overlap_idle_and_nondata_protocol_tb.sv
// Purpose: self-checking bench for the overlap idle and non-data block
// Assumes: events are one-cycle pulses driven 1 ns after the rising edge
// Notes: overlap cases run from a row table, non-data cases by hand
`timescale 1ns/10ps
`default_nettype none
module overlap_idle_and_nondata_protocol_tb;
	import ovl_proto_pkg::*;
	typedef struct packed {
		logic pend;
		logic serv;
		logic nien;
		cmd_kind_t kind;
		proto_state_t exp_st;
		logic exp_irq;
	} row_t;
	localparam row_t ROWS [7] = '{
		'{1'b1, 1'b0, 1'b0, CMD_OVERLAP, sel_intr_released_idle, 1'b1},
		'{1'b0, 1'b0, 1'b0, CMD_OVERLAP, sel_nointr_released_idle, 1'b0},
		'{1'b1, 1'b0, 1'b1, CMD_OVERLAP, sel_nointr_released_idle, 1'b0},
		'{1'b1, 1'b1, 1'b0, CMD_SERVICE, sel_intr_service_idle, 1'b1},
		'{1'b1, 1'b1, 1'b0, CMD_OVERLAP, sel_intr_service_idle, 1'b1},
		'{1'b0, 1'b1, 1'b0, CMD_OVERLAP, sel_nointr_service_idle, 1'b0},
		'{1'b1, 1'b1, 1'b1, CMD_SERVICE, sel_nointr_service_idle, 1'b0}};
	logic core_clk_i, reset_n_i, dev_wr, dev_sel, cmd_wr, status_rd, nien, done, exec_error;
	logic rel, rel_pend, rel_serv, start, bsy, drq, err, intrq, intrq_oe, svc_go, new_go;
	logic h_cmd_wr, h_rd, h_done, h_err;
	logic [TAG_W-1:0] tag, svc_tag;
	cmd_kind_t kind;
	proto_state_t st;
	int errors, cmp_count, n;
	ovl_nodata_proto u_dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .dev_wr_i(dev_wr),
		.dev_sel_this_i(dev_sel), .cmd_wr_i(cmd_wr | h_cmd_wr), .cmd_kind_i(kind),
		.status_rd_i(status_rd | h_rd), .nien_i(nien), .exec_done_i(done), .exec_error_i(exec_error),
		.release_i(rel), .release_pend_i(rel_pend), .release_serv_i(rel_serv), .svc_tag_i(tag),
		.bsy_o(bsy), .drq_o(drq), .err_o(err), .intrq_o(intrq), .intrq_oe_o(intrq_oe),
		.service_go_o(svc_go), .new_cmd_go_o(new_go), .service_tag_o(svc_tag), .state_o(st));
	host_nodata_model u_host (.core_clk_i(core_clk_i), .start_i(start), .nien_i(nien), .intrq_i(intrq),
		.bsy_i(bsy), .err_i(err), .cmd_wr_o(h_cmd_wr), .status_rd_o(h_rd), .done_o(h_done),
		.err_seen_o(h_err));
	task automatic complete_run();
		if (errors == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Waits one edge first so the same strobe is never set and cleared in one step
	task automatic ev(input int k);
		@(posedge core_clk_i);
		#1;
		case (k)
			0: dev_wr = 1'b1;
			1: cmd_wr = 1'b1;
			2: status_rd = 1'b1;
			3: done = 1'b1;
			default: rel = 1'b1;
		endcase
		@(posedge core_clk_i);
		#1 {dev_wr, cmd_wr, status_rd, done, rel} = 5'h00;
	endtask
	task automatic do_reset();
		reset_n_i = 1'b0;
		repeat (3) @(posedge core_clk_i);
		chk({st, intrq_oe, bsy}, {sel_nointr_plain_idle, 2'b10});
		#1 reset_n_i = 1'b1;
	endtask
	task automatic host_run(input logic ni, input logic er);
		do_reset();
		nien = ni;
		exec_error = er;
		start = 1'b1;
		@(posedge core_clk_i);
		#1 start = 1'b0;
		for (n = 0; n < RESP_MAX_CYC && bsy !== 1'b1; n++) @(posedge core_clk_i);
		#2 chk({bsy, st}, {1'b1, nodata_execute_state});
		repeat (ni ? 50 : 3) @(posedge core_clk_i);
		ev(3);
		chk({bsy, intrq, err, st}, {1'b0, !ni, er, ni ? sel_nointr_plain_idle : sel_intr_plain_idle});
		for (n = 0; n < 200 && h_done !== 1'b1; n++) @(posedge core_clk_i);
		#2 chk({h_done, h_err, intrq, bsy, drq, st}, {1'b1, er, 3'b000, sel_nointr_plain_idle});
	endtask
	initial begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end
	initial begin
		#100000;
		errors++;
		complete_run();
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{reset_n_i, dev_wr, dev_sel, cmd_wr, status_rd, nien, done, exec_error} = 8'h00;
		{rel, rel_pend, rel_serv, start, tag, kind} = '0;
		errors = 0;
		cmp_count = 0;
		for (int i = 0; i < 7; i++) begin
			do_reset();
			nien = ROWS[i].nien;
			rel_pend = ROWS[i].pend;
			rel_serv = ROWS[i].serv;
			ev(4);
			chk({st, intrq}, {ROWS[i].exp_st, ROWS[i].exp_irq});
			dev_sel = 1'b0;
			ev(0);
			chk({st, intrq_oe, bsy, drq}, {deselected_overlap_idle, 3'b000});
			dev_sel = 1'b1;
			ev(0);
			chk({st, intrq, intrq_oe}, {ROWS[i].exp_st, ROWS[i].exp_irq, 1'b1});
			if (ROWS[i].serv) begin
				kind = ROWS[i].kind;
				tag = TAG_W'(i + 3);
				ev(1);
				chk({svc_go, new_go, intrq}, {kind == CMD_SERVICE, kind == CMD_OVERLAP, 1'b0});
				if (kind == CMD_SERVICE) chk(svc_tag, tag);
			end
		end
		kind = CMD_NODATA;
		host_run(1'b0, 1'b1);
		host_run(1'b1, 1'b0);
		// Status read in the interrupting overlap idles drops INTRQ and keeps REL or SERV
		do_reset();
		nien = 1'b0;
		rel_pend = 1'b1;
		for (int s = 0; s < 2; s++) begin
			rel_serv = s[0];
			ev(4);
			ev(2);
			chk({st, intrq, intrq_oe}, {s ? sel_nointr_service_idle : sel_nointr_released_idle, 2'b01});
		end
		do_reset();
		nien = 1'b0;
		ev(1);
		ev(3);
		chk({intrq, st}, {1'b1, sel_intr_plain_idle});
		nien = 1'b1;
		@(posedge core_clk_i);
		#1 chk({intrq, st}, {1'b0, sel_nointr_plain_idle});
		complete_run();
	end
endmodule
`default_nettype wire
